// ==== setup_ram_defines.vh ====
/*
  Constants for the setup register and RAM pointer access block:
  register offsets, field positions, reset values and counts.
  Assumes it is included by its bare name from the design files.
*/
`ifndef SETUP_RAM_DEFINES_VH
`define SETUP_RAM_DEFINES_VH

// Register offsets on the 3-bit host address
`define OFS_PTR_HIGH     3'h2
`define OFS_PTR_LOW      3'h3
`define OFS_DATA         3'h4
`define OFS_SHARED       3'h7

// Sub-select pattern that reaches the setup register at the shared offset
`define SUBSEL_SETUP     2'h2

// Setup register fields
`define SETUP_RESET      8'h00
`define BIT_DRIVE_SEL    7
`define BIT_SHORT_LIMIT  6
`define BIT_DIV_THREE    5
`define BIT_PROMISC      4
`define FLD_RATE_HI      3
`define FLD_RATE_LO      1
`define BIT_HALF_ARB     0

// Pointer high register fields
`define BIT_AUTO_INC     7
`define FLD_PTRH_HI      2
`define PTR_RESET        11'h000

// Refusal limits for the excess refusal flag
`define REFUSAL_SHORT    8'h04
`define REFUSAL_LONG     8'h80

// Rate divisor is the base shifted left by the code; top legal code
`define RATE_BASE        9'h008
`define RATE_CODE_MAX    3'h5

// Depth of the write staging FIFO
`define WR_FIFO_DEPTH    16

`endif

// ==== stage_fifo.v ====
/*
  Synchronous FIFO built from flip-flops, valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module stage_fifo #(
  parameter WIDTH  = 8,
  parameter DEPTH  = 16,
  parameter ADDR_W = 4
) (
  input  wire             clock,    // System clock
  input  wire             rst_n,    // Async reset, active low
  input  wire             inValid,  // Producer offers a word
  output wire             inReady,  // Room for a word
  input  wire [WIDTH-1:0] inData,   // Word to store
  output wire             outValid, // A word is waiting
  input  wire             outReady, // Consumer takes the word
  output wire [WIDTH-1:0] outData   // Oldest word
);

  reg [WIDTH-1:0]  mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wrIdx_q;
  reg [ADDR_W-1:0] rdIdx_q;
  reg [ADDR_W:0]   count_q;
  wire             push;
  wire             pop;

  // Full and empty come straight from the occupancy count
  assign inReady  = (count_q != DEPTH[ADDR_W:0]);
  assign outValid = (count_q != {(ADDR_W+1){1'b0}});
  assign outData  = mem[rdIdx_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage has no reset; only the indices and the count need a defined state
  always @(posedge clock) begin
    if (push) begin
      mem[wrIdx_q] <= inData;
    end
  end

  // Indices wrap explicitly so a depth other than a power of two works
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrIdx_q <= {ADDR_W{1'b0}};
      rdIdx_q <= {ADDR_W{1'b0}};
      count_q <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wrIdx_q <= (wrIdx_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wrIdx_q + 1'b1;
      end
      if (pop) begin
        rdIdx_q <= (rdIdx_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rdIdx_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ==== setup_ram_access.v ====
/*
  Setup register and pointer-based sequential access to the 2K x 8
  packet RAM, with a staging FIFO for data writes.
  Assumes host strobes and protocol-engine signals are synchronous to
  clock; only the pulse line pin is asynchronous.
  Assumes the host reloads the pointer before it switches between
  reading and writing, and leaves a few cycles between a pointer load
  and its first data read; a read that comes early returns the old
  data register. RAM content is not reset.
*/
`timescale 1ns/1ps
`include "setup_ram_defines.vh"
module setup_ram_access #(
  parameter RAM_AW  = 11,
  parameter FIFO_D  = `WR_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input  wire       clock,              // System clock, 10 MHz
  input  wire       rst_n,              // Async reset, active low
  input  wire [2:0] busAddr,            // Register offset
  input  wire [7:0] busWrData,          // Write data
  input  wire       busWrite,           // Write strobe, one cycle
  input  wire       busRead,            // Read strobe, one cycle
  output wire       busWriteReady,      // Write would be taken now
  output reg  [7:0] busRdData,          // Read data, valid after busRead
  input  wire [1:0] registerSubselect,  // Shared offset selector
  input  wire       linePulseReq,       // Engine asks for a line pulse
  input  wire       backplaneMode,      // Backplane signalling selected
  input  wire       firstLinePulseIn_n, // Pulse pin level as seen
  output reg        firstLinePulseOut_n,// Pulse pin drive value
  output reg        firstLinePulseOe,   // Pulse pin driven
  output reg        lineHeldLow,        // Synchronised pin level is low
  input  wire       refusalSeen,        // Refusal to buffer enquiry, pulse
  input  wire       excessRefusalClear, // Clears flag and count, pulse
  output reg        excessRefusalFlag,  // Sticky excess refusal flag
  input  wire       rxPacketValid,      // Valid packet received, pulse
  input  wire [7:0] rxDestId,           // Its destination identifier
  input  wire [7:0] nodeId,             // Our programmed node identifier
  output reg        acceptPacket,       // Keep the packet, pulse
  output reg        sendAck,            // Acknowledge the packet, pulse
  output reg        timeoutDivideThree, // Short timeouts selected
  output reg        promiscuousReceive, // Receive-all selected
  output reg        rateEnable,         // Data-rate tick, pulse
  output reg        arbEnable           // Memory arbitration slot, every cycle or every other
);

  reg  [7:0]        setup_q;
  reg  [2:0]        ptrHighStage_q;
  reg               autoInc_q;
  reg  [RAM_AW-1:0] ptr_q;
  reg  [7:0]        dataReg_q;
  reg               fetchPend_q;
  reg  [7:0]        ram [0:(1<<RAM_AW)-1];
  reg  [7:0]        refusalCount_q;
  reg  [7:0]        rateCount_q;
  reg               pinMeta_q;
  reg               pinSync_q;
  reg  [7:0]        rdMux;
  reg  [7:0]        rateTop;
  reg  [8:0]        rateDiv;
  reg  [7:0]        refusalLimit;
  wire              wrHit;
  wire              dataWrite;
  wire              dataRead;
  wire              lowWrite;
  wire              setupSel;
  wire              fetchReq;
  wire              fetchGo;
  wire              fifoInReady;
  wire              fifoOutValid;
  wire [RAM_AW+7:0] fifoOut;
  wire [2:0]        rateCode;
  wire [8:0]        refusalNext;

  // Shared offset reaches the setup register only for pattern 1,0
  assign setupSel  = (busAddr == `OFS_SHARED) && (registerSubselect == `SUBSEL_SETUP);
  assign dataWrite = busWrite && (busAddr == `OFS_DATA) && fifoInReady;
  assign dataRead  = busRead && (busAddr == `OFS_DATA);
  assign lowWrite  = busWrite && (busAddr == `OFS_PTR_LOW);
  assign wrHit     = busWrite && (busAddr != `OFS_DATA);

  // Only a data write can be held back, and only while the FIFO is full
  // Register writes are never held, so setup and pointer loads always land
  assign busWriteReady = fifoInReady || (busAddr != `OFS_DATA);

  // A fetch follows a pointer load or an auto-incrementing data read
  assign fetchReq = lowWrite || (autoInc_q && dataRead);

  // Fetch waits until staged writes are committed, so it sees fresh data
  // The price is a longer first-read latency while writes are draining
  assign fetchGo = fetchPend_q && arbEnable && !fifoOutValid;

  // Setup register; reserved rate codes are stored as written
  // so software reads back exactly what it wrote
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= `SETUP_RESET;
    end else if (wrHit && setupSel) begin
      setup_q <= busWrData;
    end
  end

  // Decoded setup fields presented to the rest of the controller
  // Registered so downstream timers see a clean level, one cycle late
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timeoutDivideThree <= 1'b0;
      promiscuousReceive <= 1'b0;
    end else begin
      timeoutDivideThree <= setup_q[`BIT_DIV_THREE];
      promiscuousReceive <= setup_q[`BIT_PROMISC];
    end
  end

  // Pointer: high byte is staged, the low write loads the full address
  // A high write alone never moves the pointer, so it may be staged early
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptrHighStage_q <= 3'h0;
      autoInc_q      <= 1'b0;
      ptr_q          <= `PTR_RESET;
    end else begin
      if (busWrite && (busAddr == `OFS_PTR_HIGH)) begin
        ptrHighStage_q <= busWrData[`FLD_PTRH_HI:0];
        autoInc_q      <= busWrData[`BIT_AUTO_INC];
      end
      if (lowWrite) begin
        ptr_q <= {ptrHighStage_q, busWrData};
      end else if (autoInc_q && (dataWrite || dataRead)) begin
        ptr_q <= ptr_q + 1'b1;
      end
    end
  end

  // Pending fetch; a new request in the serving cycle keeps it pending
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetchPend_q <= 1'b0;
    end else if (fetchReq) begin
      fetchPend_q <= 1'b1;
    end else if (fetchGo) begin
      fetchPend_q <= 1'b0;
    end
  end

  // Data register is filled only by prefetch; the host never sees the RAM
  // Its reset value only shows to a read made before the first fetch completes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataReg_q <= 8'h00;
    end else if (fetchGo) begin
      dataReg_q <= ram[ptr_q];
    end
  end

  // Staged writes carry their own address, so later pointer moves are safe
  stage_fifo #(
    .WIDTH  (RAM_AW + 8),
    .DEPTH  (FIFO_D),
    .ADDR_W (FIFO_AW)
  ) writeStage (
    .clock    (clock),
    .rst_n    (rst_n),
    .inValid  (dataWrite),
    .inReady  (fifoInReady),
    .inData   ({ptr_q, busWrData}),
    .outValid (fifoOutValid),
    .outReady (arbEnable),
    .outData  (fifoOut)
  );

  // RAM commit happens in an arbitration slot, never in the bus cycle
  // The array has no reset; it is plain storage that software must fill
  always @(posedge clock) begin
    if (fifoOutValid && arbEnable) begin
      ram[fifoOut[RAM_AW+7:8]] <= fifoOut[7:0];
    end
  end

  // Read multiplexer; unused offsets and other sub-selects read zero
  always @* begin
    rdMux = 8'h00;
    case (busAddr)
      `OFS_PTR_HIGH: begin
        rdMux = {autoInc_q, 4'h0, ptr_q[RAM_AW-1:8]};
      end
      `OFS_PTR_LOW: begin
        rdMux = ptr_q[7:0];
      end
      `OFS_DATA: begin
        rdMux = dataReg_q;
      end
      `OFS_SHARED: begin
        rdMux = setupSel ? setup_q : 8'h00;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read
  // Holding it lets a slow host sample the value whenever it likes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busRdData <= 8'h00;
    end else if (busRead) begin
      busRdData <= rdMux;
    end
  end

  // Arbitration slots every cycle, or every other cycle when halved
  // Halving slows commits and fetches; a long burst of data writes can fill the FIFO and then wait
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arbEnable <= 1'b1;
    end else if (setup_q[`BIT_HALF_ARB]) begin
      arbEnable <= ~arbEnable;
    end else begin
      arbEnable <= 1'b1;
    end
  end

  // Reserved rate codes fall back to the slowest divisor
  // The top count is one less than the divisor; 256 wraps to 8'hFF here
  assign rateCode = setup_q[`FLD_RATE_HI:`FLD_RATE_LO];
  always @* begin
    rateDiv = 9'h000;
    if (rateCode > `RATE_CODE_MAX) begin
      rateDiv = `RATE_BASE << `RATE_CODE_MAX;
    end else begin
      rateDiv = `RATE_BASE << rateCode;
    end
    rateTop = rateDiv[7:0] - 1'b1;
  end

  // Rate divider; a top that shrinks to or below the count restarts it at once
  // A growing divisor just counts on to the new top, so no tick is lost
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rateCount_q <= 8'h00;
      rateEnable  <= 1'b0;
    end else if (rateCount_q >= rateTop) begin
      rateCount_q <= 8'h00;
      rateEnable  <= 1'b1;
    end else begin
      rateCount_q <= rateCount_q + 1'b1;
      rateEnable  <= 1'b0;
    end
  end

  // Refusal limit follows the setup bit at the time of each refusal
  always @* begin
    refusalLimit = setup_q[`BIT_SHORT_LIMIT] ? `REFUSAL_SHORT : `REFUSAL_LONG;
  end

  // Count including this refusal, one bit wider so a saturated count never wraps
  assign refusalNext = {1'b0, refusalCount_q} + 9'h001;

  // Refusal counter; a refusal in the clearing cycle is still counted.
  // Reaching the limit as a clear arrives sets the flag: the set wins, so a
  // racing clear cannot hide an excess
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refusalCount_q    <= 8'h00;
      excessRefusalFlag <= 1'b0;
    end else if (refusalSeen) begin
      if (excessRefusalClear) begin
        refusalCount_q <= 8'h01;
      end else if (refusalCount_q != 8'hFF) begin
        refusalCount_q <= refusalCount_q + 1'b1;
      end
      if (refusalNext >= {1'b0, refusalLimit}) begin
        excessRefusalFlag <= 1'b1;
      end else if (excessRefusalClear) begin
        excessRefusalFlag <= 1'b0;
      end
    end else if (excessRefusalClear) begin
      refusalCount_q    <= 8'h00;
      excessRefusalFlag <= 1'b0;
    end
  end

  // Packet filter: accept widens in receive-all, acknowledge never does
  // Broadcast is left to the engine; only exact and receive-all matches here
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acceptPacket <= 1'b0;
      sendAck      <= 1'b0;
    end else begin
      acceptPacket <= rxPacketValid && ((rxDestId == nodeId) || setup_q[`BIT_PROMISC]);
      sendAck      <= rxPacketValid && (rxDestId == nodeId);
    end
  end

  // Pulse pin: open-drain releases when idle, push-pull always drives
  // Open drain never drives high; the line relies on its pull-up
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      firstLinePulseOut_n <= 1'b1;
      firstLinePulseOe    <= 1'b0;
    end else if (backplaneMode && !setup_q[`BIT_DRIVE_SEL]) begin
      firstLinePulseOut_n <= 1'b0;
      firstLinePulseOe    <= linePulseReq;
    end else begin
      firstLinePulseOut_n <= ~linePulseReq;
      firstLinePulseOe    <= 1'b1;
    end
  end

  // Pin level crosses in through two flops before anyone reads it
  // Flops reset to the idle high level so no false low follows reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_q   <= 1'b1;
      pinSync_q   <= 1'b1;
      lineHeldLow <= 1'b0;
    end else begin
      pinMeta_q   <= firstLinePulseIn_n;
      pinSync_q   <= pinMeta_q;
      lineHeldLow <= ~pinSync_q;
    end
  end

endmodule

// ==== setup_ram_access_props.sv ====
/*
  Port-level assertions for setup_ram_access.
  Assumes binding to every instance; one clock, reset active low.
*/
`timescale 1ns/1ps
module setup_ram_access_props (
  input wire       clock,              // System clock
  input wire       rst_n,              // Async reset, active low
  input wire [2:0] busAddr,            // Register offset
  input wire       busWrite,           // Write strobe
  input wire       busRead,            // Read strobe
  input wire       busWriteReady,      // Write would be taken
  input wire [7:0] busRdData,          // Read data
  input wire [1:0] registerSubselect,  // Shared offset selector
  input wire       refusalSeen,        // Refusal pulse
  input wire       excessRefusalClear, // Flag clear pulse
  input wire       excessRefusalFlag,  // Sticky flag
  input wire       rxPacketValid,      // Packet pulse
  input wire [7:0] rxDestId,           // Destination identifier
  input wire [7:0] nodeId,             // Own identifier
  input wire       acceptPacket,       // Keep pulse
  input wire       sendAck,            // Acknowledge pulse
  input wire       timeoutDivideThree, // Short timeouts
  input wire       rateEnable,         // Rate tick
  input wire       arbEnable           // Arbitration slot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Setup register write as seen on the bus
  wire setupWr = busWrite && busAddr == 3'h7 && registerSubselect == 2'h2;
  // A packet for our own node is both kept and acknowledged next cycle
  sequence ackBoth;
    ##1 (acceptPacket && sendAck);
  endsequence
  a_ack_own_id: assert property (rxPacketValid && rxDestId == nodeId |-> ackBoth) else $error("own packet not acked");
  a_ack_foreign_id: assert property (rxPacketValid && rxDestId != nodeId |=> !sendAck) else $error("foreign packet acked");
  a_no_spurious: assert property (!rxPacketValid |=> !acceptPacket && !sendAck) else $error("pulse without packet");
  a_flag_sticky: assert property (excessRefusalFlag && !excessRefusalClear |=> excessRefusalFlag) else $error("flag dropped");
  a_flag_cause: assert property ($rose(excessRefusalFlag) |-> $past(refusalSeen)) else $error("flag set without refusal");
  a_flag_clear: assert property (excessRefusalClear && !refusalSeen |=> !excessRefusalFlag) else $error("flag not cleared");
  a_rate_gap: assert property (rateEnable |=> !rateEnable) else $error("rate tick too close");
  a_arb_half: assert property (!arbEnable |=> arbEnable) else $error("arbitration slot lost twice");
  a_read_hold: assert property (!busRead |=> $stable(busRdData)) else $error("read data moved");
  a_write_ready: assert property (busAddr != 3'h4 |-> busWriteReady) else $error("register write refused");
  a_div3_cause: assert property ($changed(timeoutDivideThree) |-> $past(setupWr) || $past(setupWr, 2)) else $error("div3 moved alone");
endmodule
bind setup_ram_access setup_ram_access_props setup_ram_access_props_inst (
  .clock(clock), .rst_n(rst_n), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
  .busWriteReady(busWriteReady), .busRdData(busRdData), .registerSubselect(registerSubselect),
  .refusalSeen(refusalSeen), .excessRefusalClear(excessRefusalClear), .excessRefusalFlag(excessRefusalFlag),
  .rxPacketValid(rxPacketValid), .rxDestId(rxDestId), .nodeId(nodeId), .acceptPacket(acceptPacket),
  .sendAck(sendAck), .timeoutDivideThree(timeoutDivideThree), .rateEnable(rateEnable), .arbEnable(arbEnable));

// ==== host_model.sv ====
/*
  Host microcontroller model on the register bus.
  Assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module host_model (
  input  wire       clock,            // System clock
  output reg  [2:0] busAddr,          // Register offset
  output reg  [7:0] busWrData,        // Write data
  output reg        busWrite,         // Write strobe
  output reg        busRead,          // Read strobe
  input  wire       busWriteReady,    // Write would be taken now
  output reg  [1:0] registerSubselect // Shared offset selector
);
  // Idle bus; clock is 10 MHz so half-rate arbitration stays optional
  initial begin
    busAddr = 3'h0;
    busWrData = 8'h5A;
    busWrite = 1'b0;
    busRead = 1'b0;
    registerSubselect = 2'h2;
  end
  // One-cycle write; data inverted after so no stale value lingers
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clock);
    #1;
    busAddr = a;
    busWrData = d;
    busWrite = 1'b1;
    @(posedge clock);
    // A data write into a full staging FIFO is held until it is taken
    while (busWriteReady !== 1'b1) @(posedge clock);
    #1;
    busWrite = 1'b0;
    busWrData = ~d;
  endtask
  // One-cycle read; data shows up one edge later
  task rd(input [2:0] a);
    @(posedge clock);
    #1;
    busAddr = a;
    busRead = 1'b1;
    @(posedge clock);
    #1;
    busRead = 1'b0;
  endtask
endmodule

// ==== tb_top.sv ====
/*
  Self-checking bench for setup_ram_access with a host model.
  Assumes a 100 ns clock; read and packet expectations are queued, a monitor compares.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock, rst_n, linePulseReq, backplaneMode, refusalSeen, excessRefusalClear, rxPacketValid;
  logic [7:0] rxDestId, nodeId, v, d;
  wire [2:0] busAddr;
  wire [7:0] busWrData, busRdData;
  wire [1:0] registerSubselect;
  wire busWrite, busRead, busWriteReady, pulseOut_n, pulseOe, lineHeldLow, excessRefusalFlag;
  wire acceptPacket, sendAck, timeoutDivideThree, promiscuousReceive, rateEnable, arbEnable;
  // Pin has a pull-up when nobody drives it
  wire pinLevel = pulseOe ? pulseOut_n : 1'b1;
  int failCount = 0, nTests = 0, n;
  logic [7:0] rdQ[$], mem[$];
  logic [1:0] pkQ[$];
  logic rdPend = 1'b0, pkPend = 1'b0;
  setup_ram_access setup_ram_access_inst (.clock(clock), .rst_n(rst_n), .busAddr(busAddr),
    .busWrData(busWrData), .busWrite(busWrite), .busRead(busRead), .busWriteReady(busWriteReady),
    .busRdData(busRdData), .registerSubselect(registerSubselect), .linePulseReq(linePulseReq),
    .backplaneMode(backplaneMode), .firstLinePulseIn_n(pinLevel), .firstLinePulseOut_n(pulseOut_n),
    .firstLinePulseOe(pulseOe), .lineHeldLow(lineHeldLow), .refusalSeen(refusalSeen),
    .excessRefusalClear(excessRefusalClear), .excessRefusalFlag(excessRefusalFlag),
    .rxPacketValid(rxPacketValid), .rxDestId(rxDestId), .nodeId(nodeId), .acceptPacket(acceptPacket),
    .sendAck(sendAck), .timeoutDivideThree(timeoutDivideThree), .promiscuousReceive(promiscuousReceive),
    .rateEnable(rateEnable), .arbEnable(arbEnable));
  host_model host_model_inst (.clock(clock), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busWriteReady(busWriteReady), .registerSubselect(registerSubselect));
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task completeRun;
    if (failCount == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task rdExp(input [2:0] a, input [7:0] e);
    rdQ.push_back(e);
    host_model_inst.rd(a);
  endtask
  task refuse(input int k);
    repeat (k) begin
      refusalSeen = 1'b1;
      cyc(1);
      refusalSeen = 1'b0;
      cyc(1);
    end
  endtask
  task clearFlag;
    excessRefusalClear = 1'b1;
    cyc(1);
    excessRefusalClear = 1'b0;
    cyc(1);
    check("flagCleared", excessRefusalFlag, 0);
  endtask
  // Packet pulse; outcome follows from ids and receive-all setting
  task pkt(input [7:0] dst, input [7:0] own, input bit all);
    rxDestId = dst;
    nodeId = own;
    rxPacketValid = 1'b1;
    pkQ.push_back({dst == own || all, dst == own});
    cyc(1);
    rxPacketValid = 1'b0;
    cyc(1);
  endtask
  // Monitor: registered results land one edge after their strobe
  always @(posedge clock) begin
    if (rdPend) check("busRdData", busRdData, rdQ.pop_front());
    if (pkPend) check("acceptAck", {acceptPacket, sendAck}, pkQ.pop_front());
    rdPend <= busRead;
    pkPend <= rxPacketValid;
  end
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Watchdog sized well above the longest rate sweep
  initial begin
    #3_000_000;
    failCount++;
    completeRun();
  end
  initial begin
    rst_n = 1'b0;
    {linePulseReq, refusalSeen, excessRefusalClear, rxPacketValid} = 4'h0;
    backplaneMode = 1'b1;
    rxDestId = 8'h00;
    nodeId = 8'h00;
    v = 8'($urandom(32'h3463_6feb));
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    cyc(1);
    rdExp(3'h7, 8'h00);
    rdExp(3'h0, 8'h00);
    host_model_inst.registerSubselect = 2'h1;
    rdExp(3'h7, 8'h00);
    host_model_inst.registerSubselect = 2'h2;
    // Open drain by default: pin pulled low only while pulsing
    linePulseReq = 1'b1;
    cyc(3);
    check("pulseOe", pulseOe, 1);
    check("pulseOut", pulseOut_n, 0);
    cyc(3);
    check("heldLow", lineHeldLow, 1);
    host_model_inst.wr(3'h7, 8'h80);
    linePulseReq = 1'b0;
    cyc(3);
    check("pushPullOe", pulseOe, 1);
    check("pushPullOut", pulseOut_n, 1);
    // Every rate code, random upper bits, gap between ticks measured
    for (int c = 0; c < 8; c++) begin
      v = 8'($urandom & 32'h0000_00F1) | 8'(c << 1);
      host_model_inst.wr(3'h7, v);
      rdExp(3'h7, v);
      check("div3", timeoutDivideThree, v[5]);
      check("promisc", promiscuousReceive, v[4]);
      d = 8'($urandom);
      pkt(d, d, v[4]);
      pkt(d, d ^ 8'h01, v[4]);
      n = 0;
      while (rateEnable !== 1'b1 && n < 600) begin
        cyc(1);
        n++;
      end
      cyc(1);
      n = 1;
      while (rateEnable !== 1'b1 && n < 600) begin
        cyc(1);
        n++;
      end
      check("rateGap", 16'(n), 16'(8 << (c > 5 ? 5 : c)));
    end
    // Short then long refusal limit, both boundaries
    host_model_inst.wr(3'h7, 8'h40);
    clearFlag();
    refuse(3);
    check("flagAt3", excessRefusalFlag, 0);
    refuse(1);
    check("flagAt4", excessRefusalFlag, 1);
    host_model_inst.wr(3'h7, 8'h00);
    clearFlag();
    refuse(127);
    check("flagAt127", excessRefusalFlag, 0);
    refuse(1);
    check("flagAt128", excessRefusalFlag, 1);
    // Outside backplane signalling the pin is push-pull whatever bit 7 holds
    backplaneMode = 1'b0;
    linePulseReq = 1'b1;
    cyc(2);
    check("normalOe", pulseOe, 1);
    check("normalOut", pulseOut_n, 0);
    linePulseReq = 1'b0;
    backplaneMode = 1'b1;
    cyc(2);
    check("odReleased", pulseOe, 0);
    // Slow arbitration, auto-increment across the top of RAM
    host_model_inst.wr(3'h7, 8'h01);
    host_model_inst.wr(3'h2, 8'h87);
    host_model_inst.wr(3'h3, 8'hF8);
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom);
      mem.push_back(v);
      host_model_inst.wr(3'h4, v);
    end
    host_model_inst.wr(3'h2, 8'h87);
    host_model_inst.wr(3'h3, 8'hF8);
    cyc(4);
    for (int i = 0; i < 12; i++) begin
      rdExp(3'h4, mem.pop_front());
      cyc(3);
    end
    rdExp(3'h2, 8'h80);
    cyc(3);
    completeRun();
  end
endmodule
